// File: rtl/usp_pkg.sv
// Constants and types shared by the serial port with baud rate generator.
package usp_pkg;

  // Register addresses on the core-side register port.
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CONTROL       = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER       = 8'h99;
  localparam logic [7:0] ADDR_BRL        = 8'h9A;
  localparam logic [7:0] ADDR_BAUD_CTRL  = 8'h9B;
  localparam logic [7:0] ADDR_SLAVE_ADDRESS      = 8'hA9;
  localparam logic [7:0] ADDR_SLAVE_ADDRESS_MASK      = 8'hB9;

  // Serial control field positions.
  localparam int unsigned SC_FE_SM0 = 7;
  localparam int unsigned SC_SM1    = 6;
  localparam int unsigned SC_SM2    = 5;
  localparam int unsigned SC_REN    = 4;
  localparam int unsigned SC_TB8    = 3;
  localparam int unsigned SC_RB8    = 2;
  localparam int unsigned SC_TI     = 1;
  localparam int unsigned SC_RI     = 0;

  // Power control and baud control field positions.
  localparam int unsigned PC_DOUBLER   = 7;
  localparam int unsigned PC_FE_ACCESS = 6;
  localparam int unsigned BC_RUN       = 4;
  localparam int unsigned BC_TX_GEN    = 3;
  localparam int unsigned BC_RX_GEN    = 2;
  localparam int unsigned BC_SPEED     = 1;
  localparam int unsigned BC_M0_SRC    = 0;

  // Reset values.
  localparam logic [7:0] SERIAL_CONTROL_RESET  = 8'h00;
  localparam logic [7:0] SLAVE_ADDRESS_MASK_RESET = 8'h00;
  localparam logic [7:0] SLAVE_ADDRESS_RESET = 8'h00;
  localparam logic [7:0] OTHER_RESET = 8'h00;

  // Mode codes and timing counts.
  localparam logic [1:0] MODE_SHIFT  = 2'h0;
  localparam logic [1:0] MODE_FIXED9 = 2'h2;
  localparam logic [2:0] BRG_PRE_LAST = 3'h5;
  localparam logic [7:0] BRG_TOP      = 8'hFF;
  localparam logic [1:0] M0_HALF_LAST = 2'h2;
  localparam logic [3:0] OVS_LAST     = 4'hF;
  localparam logic [3:0] START_SAMPLE = 4'h7;
  localparam logic [2:0] BIT_LAST     = 3'h7;

  typedef enum logic [2:0] {USP_TX_IDLE, USP_TX_START, USP_TX_DATA, USP_TX_NINTH, USP_TX_STOP, USP_TX_SHIFT} usp_tx_state_t;
  typedef enum logic [2:0] {USP_RX_IDLE, USP_RX_START, USP_RX_DATA, USP_RX_NINTH, USP_RX_STOP} usp_rx_state_t;

endpackage : usp_pkg

// File: rtl/usp_rx_if.sv
// Link between the port control logic and the asynchronous receiver.
`timescale 1ns/10ps
interface usp_rx_if;
  logic       tick16;
  logic       enable;
  logic       nine_bits;
  logic       line;
  logic [7:0] data;
  logic       ninth;
  logic       stop_bit;
  logic       data_done;
  logic       stop_done;

  modport ctrl (output tick16, enable, nine_bits, line, input data, ninth, stop_bit, data_done, stop_done);
  modport rx (input tick16, enable, nine_bits, line, output data, ninth, stop_bit, data_done, stop_done);
endinterface : usp_rx_if

// File: rtl/usp_brg.sv
// Internal baud rate generator: prescaled reload counter.
`timescale 1ns/10ps
module usp_brg (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset,
  // Configuration.
  input  wire logic       run,
  input  wire logic       speed_fast,
  input  wire logic [7:0] reload,
  // Overflow pulse.
  output logic            overflow
);
  logic [2:0] pre;
  logic [2:0] next_pre;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_overflow;
  logic       pre_tick;

  // Divide by six in slow speed, then count from the reload value up to the top.
  always_comb begin
    pre_tick      = speed_fast | (pre == usp_pkg::BRG_PRE_LAST);
    next_pre      = pre;
    next_cnt      = cnt;
    next_overflow = 1'b0;
    if (!run) begin
      next_pre = 3'h0;
      next_cnt = reload;
    end else begin
      next_pre = pre_tick ? 3'h0 : 3'(pre + 3'h1);
      if (pre_tick) begin
        if (cnt == usp_pkg::BRG_TOP) begin
          next_cnt      = reload;
          next_overflow = 1'b1;
        end else begin
          next_cnt = 8'(cnt + 8'h01);
        end
      end
    end
  end

  // Counter registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      pre      <= 3'h0;
      cnt      <= 8'h00;
      overflow <= 1'b0;
    end else begin
      pre      <= next_pre;
      cnt      <= next_cnt;
      overflow <= next_overflow;
    end
  end
endmodule : usp_brg

// File: rtl/usp_rx.sv
// Asynchronous frame receiver with sixteen-times oversampling.
`timescale 1ns/10ps
module usp_rx (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset,
  // Link to the control logic.
  usp_rx_if.rx      rx
);
  usp_pkg::usp_rx_state_t state;
  usp_pkg::usp_rx_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] next_data;
  logic       next_ninth;
  logic       next_stop_bit;
  logic       next_data_done;
  logic       next_stop_done;
  logic       sample;

  // Frame walk: start check at mid start bit, then one sample per sixteen ticks.
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_bit_idx   = bit_idx;
    next_shift     = shift;
    next_data      = rx.data;
    next_ninth     = rx.ninth;
    next_stop_bit  = rx.stop_bit;
    next_data_done = 1'b0;
    next_stop_done = 1'b0;
    sample         = rx.tick16 & (cnt == usp_pkg::OVS_LAST);
    if (rx.tick16 && !sample) begin
      next_cnt = 4'(cnt + 4'h1);
    end
    unique case (state)
      usp_pkg::USP_RX_IDLE: begin
        next_cnt = 4'h0;
        if (!rx.line) begin
          next_state = usp_pkg::USP_RX_START;
        end
      end
      usp_pkg::USP_RX_START: begin
        if (rx.tick16 && cnt == usp_pkg::START_SAMPLE) begin
          next_cnt     = 4'h0;
          next_bit_idx = 3'h0;
          next_state   = rx.line ? usp_pkg::USP_RX_IDLE : usp_pkg::USP_RX_DATA;
        end
      end
      usp_pkg::USP_RX_DATA: begin
        if (sample) begin
          next_cnt   = 4'h0;
          next_shift = {rx.line, shift[7:1]};
          if (bit_idx == usp_pkg::BIT_LAST) begin
            next_data      = {rx.line, shift[7:1]};
            next_data_done = ~rx.nine_bits;
            next_state     = rx.nine_bits ? usp_pkg::USP_RX_NINTH : usp_pkg::USP_RX_STOP;
          end else begin
            next_bit_idx = 3'(bit_idx + 3'h1);
          end
        end
      end
      usp_pkg::USP_RX_NINTH: begin
        if (sample) begin
          next_cnt       = 4'h0;
          next_ninth     = rx.line;
          next_data_done = 1'b1;
          next_state     = usp_pkg::USP_RX_STOP;
        end
      end
      usp_pkg::USP_RX_STOP: begin
        if (sample) begin
          next_cnt       = 4'h0;
          next_stop_bit  = rx.line;
          next_stop_done = 1'b1;
          next_state     = usp_pkg::USP_RX_IDLE;
        end
      end
    endcase
    if (!rx.enable) begin
      next_state     = usp_pkg::USP_RX_IDLE;
      next_data_done = 1'b0;
      next_stop_done = 1'b0;
    end
  end

  // Receiver registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      state        <= usp_pkg::USP_RX_IDLE;
      cnt          <= 4'h0;
      bit_idx      <= 3'h0;
      shift        <= 8'h00;
      rx.data      <= 8'h00;
      rx.ninth     <= 1'b0;
      rx.stop_bit  <= 1'b0;
      rx.data_done <= 1'b0;
      rx.stop_done <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      bit_idx      <= next_bit_idx;
      shift        <= next_shift;
      rx.data      <= next_data;
      rx.ninth     <= next_ninth;
      rx.stop_bit  <= next_stop_bit;
      rx.data_done <= next_data_done;
      rx.stop_done <= next_stop_done;
    end
  end
endmodule : usp_rx

// File: rtl/usp_serial_port.sv
// Enhanced serial port with shift mode, 8/9-bit UART modes and internal baud generator.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps

module usp_serial_port (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset,
  // Register port.
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  // Single-bit write port for the serial control register.
  input  wire logic       bit_wr,
  input  wire logic [2:0] bit_index,
  input  wire logic       bit_value,
  // Timer clock sources.
  input  wire logic       timer1_overflow,
  input  wire logic       timer2_overflow,
  input  wire logic       tx_timer2_select,
  input  wire logic       rx_timer2_select,
  // Serial pins.
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe,
  output logic            txd_out
);
  usp_rx_if rx_bus ();

  logic [7:0] serial_control;
  logic [7:0] next_serial_control;
  logic       fe;
  logic       next_fe;
  logic [7:0] serial_buffer_rx;
  logic [7:0] next_serial_buffer_rx;
  logic [7:0] slave_address;
  logic [7:0] slave_address_mask;
  logic [7:0] brg_reload_value;
  logic [7:0] baud_ctrl;
  logic [7:0] power_ctrl;
  logic [7:0] next_slave_address;
  logic [7:0] next_slave_address_mask;
  logic [7:0] next_brl;
  logic [7:0] next_baud_ctrl;
  logic [7:0] next_power_ctrl;
  logic [7:0] next_rd_data;
  logic [7:0] sw_mask;
  logic [7:0] sw_val;
  logic       rxd_meta;
  logic       rxd_sync;
  logic       brg_ovf;
  logic [1:0] m0_cnt;
  logic [1:0] next_m0_cnt;
  logic       fix_tog;
  logic       brg_tog_a;
  logic       brg_tog_b;
  logic       t1_tog;
  logic       next_fix_tog;
  logic       next_brg_tog_a;
  logic       next_brg_tog_b;
  logic       next_t1_tog;
  logic       brg16;
  logic       t1_16;
  logic       fixed16;
  logic       tx_tick16;
  logic       rx_tick16;
  logic       m0_half;
  logic [1:0] mode;
  logic       doubler;
  logic       fe_sel;
  logic [7:0] bcast;
  logic       addr_ok;
  logic       ninth_eff;
  logic       frame_event;
  logic       accept;
  logic       fe_set;
  logic       ti_set;
  logic       ri_m0_set;
  usp_pkg::usp_tx_state_t tx_state;
  usp_pkg::usp_tx_state_t next_tx_state;
  logic [3:0] tx_cnt;
  logic [3:0] next_tx_cnt;
  logic [2:0] tx_bit;
  logic [2:0] next_tx_bit;
  logic [7:0] tx_shift;
  logic [7:0] next_tx_shift;
  logic       m0_phase;
  logic       next_m0_phase;
  logic       m0_rx;
  logic       next_m0_rx;
  logic       next_txd_out;
  logic       next_rxd_out;
  logic       next_rxd_oe;

  // Field views of the configuration registers.
  assign mode    = {serial_control[usp_pkg::SC_FE_SM0], serial_control[usp_pkg::SC_SM1]};
  assign doubler = power_ctrl[usp_pkg::PC_DOUBLER];
  assign fe_sel  = power_ctrl[usp_pkg::PC_FE_ACCESS];

  // Internal baud generator.
  usp_brg u_brg (
    .clk        (clk),
    .reset      (reset),
    .run        (baud_ctrl[usp_pkg::BC_RUN]),
    .speed_fast (baud_ctrl[usp_pkg::BC_SPEED]),
    .reload     (brg_reload_value),
    .overflow   (brg_ovf)
  );

  // Asynchronous receiver.
  usp_rx u_rx (
    .clk   (clk),
    .reset (reset),
    .rx    (rx_bus.rx)
  );

  // Rate dividers: generator overflow halved always and again without the doubler; timer 1 overflow halved without it.
  always_comb begin
    next_m0_cnt    = (m0_cnt == usp_pkg::M0_HALF_LAST) ? 2'h0 : 2'(m0_cnt + 2'h1);
    next_fix_tog   = ~fix_tog;
    next_brg_tog_a = brg_ovf ? ~brg_tog_a : brg_tog_a;
    next_brg_tog_b = (brg_ovf & brg_tog_a) ? ~brg_tog_b : brg_tog_b;
    next_t1_tog    = timer1_overflow ? ~t1_tog : t1_tog;
  end

  // Oversampling tick selection per direction.
  assign brg16     = brg_ovf & brg_tog_a & (doubler | brg_tog_b);
  assign t1_16     = timer1_overflow & (doubler | t1_tog);
  assign fixed16   = doubler | fix_tog;
  assign tx_tick16 = (mode == usp_pkg::MODE_FIXED9) ? fixed16 :
                     baud_ctrl[usp_pkg::BC_TX_GEN] ? brg16 :
                     tx_timer2_select ? timer2_overflow : t1_16;
  assign rx_tick16 = (mode == usp_pkg::MODE_FIXED9) ? fixed16 :
                     baud_ctrl[usp_pkg::BC_RX_GEN] ? brg16 :
                     rx_timer2_select ? timer2_overflow : t1_16;
  assign m0_half   = baud_ctrl[usp_pkg::BC_M0_SRC] ? brg_ovf : (m0_cnt == usp_pkg::M0_HALF_LAST);

  // Receiver hookup; shift mode is handled by the shifter below.
  assign rx_bus.tick16    = rx_tick16;
  assign rx_bus.enable    = serial_control[usp_pkg::SC_REN] & (mode != usp_pkg::MODE_SHIFT);
  assign rx_bus.nine_bits = mode[1];
  assign rx_bus.line      = rxd_sync;

  // Address recognition and frame acceptance.
  assign bcast       = slave_address | slave_address_mask;
  assign addr_ok     = (((rx_bus.data ^ slave_address) & slave_address_mask) == 8'h00) | ((rx_bus.data & bcast) == bcast);
  assign ninth_eff   = mode[1] ? rx_bus.ninth : rx_bus.stop_bit;
  assign frame_event = (fe_sel | ~mode[1]) ? rx_bus.stop_done : rx_bus.data_done;
  assign accept      = frame_event & ~serial_control[usp_pkg::SC_RI] & (~serial_control[usp_pkg::SC_SM2] | (ninth_eff & addr_ok));
  assign fe_set      = fe_sel & rx_bus.stop_done & ~rx_bus.stop_bit;

  // Software write mask for the control register, from byte or single-bit writes.
  always_comb begin
    sw_mask = 8'h00;
    sw_val  = wr_data;
    if (wr_en && addr == usp_pkg::ADDR_SERIAL_CONTROL) begin
      sw_mask = 8'hFF;
    end else if (bit_wr) begin
      sw_mask[bit_index] = 1'b1;
      sw_val             = {8{bit_value}};
    end
  end

  // Register file next values; hardware sets win over software clears.
  always_comb begin
    next_serial_control       = (serial_control & ~sw_mask) | (sw_val & sw_mask);
    next_fe         = fe;
    next_serial_buffer_rx    = serial_buffer_rx;
    next_slave_address      = slave_address;
    next_slave_address_mask      = slave_address_mask;
    next_brl        = brg_reload_value;
    next_baud_ctrl  = baud_ctrl;
    next_power_ctrl = power_ctrl;
    if (fe_sel) begin
      next_serial_control[usp_pkg::SC_FE_SM0] = serial_control[usp_pkg::SC_FE_SM0];
      if (sw_mask[usp_pkg::SC_FE_SM0]) begin
        next_fe = sw_val[usp_pkg::SC_FE_SM0];
      end
    end
    if (fe_set) begin
      next_fe = 1'b1;
    end
    if (accept) begin
      next_serial_buffer_rx                = rx_bus.data;
      next_serial_control[usp_pkg::SC_RB8]  = ninth_eff;
      next_serial_control[usp_pkg::SC_RI]   = 1'b1;
    end
    if (ri_m0_set) begin
      next_serial_buffer_rx              = {rxd_sync, tx_shift[7:1]};
      next_serial_control[usp_pkg::SC_RI] = 1'b1;
    end
    if (ti_set) begin
      next_serial_control[usp_pkg::SC_TI] = 1'b1;
    end
    if (wr_en) begin
      unique case (addr)
        usp_pkg::ADDR_SLAVE_ADDRESS:      next_slave_address      = wr_data;
        usp_pkg::ADDR_SLAVE_ADDRESS_MASK:      next_slave_address_mask      = wr_data;
        usp_pkg::ADDR_BRL:        next_brl        = wr_data;
        usp_pkg::ADDR_BAUD_CTRL:  next_baud_ctrl  = wr_data;
        usp_pkg::ADDR_POWER_CTRL: next_power_ctrl = wr_data;
        default: ;
      endcase
    end
  end

  // Read data mux; stands for the one cycle after the read strobe.
  always_comb begin
    next_rd_data = 8'h00;
    if (rd_en) begin
      unique case (addr)
        usp_pkg::ADDR_SERIAL_CONTROL:       next_rd_data = {fe_sel ? fe : serial_control[usp_pkg::SC_FE_SM0], serial_control[6:0]};
        usp_pkg::ADDR_SERIAL_BUFFER:       next_rd_data = serial_buffer_rx;
        usp_pkg::ADDR_SLAVE_ADDRESS:      next_rd_data = slave_address;
        usp_pkg::ADDR_SLAVE_ADDRESS_MASK:      next_rd_data = slave_address_mask;
        usp_pkg::ADDR_BRL:        next_rd_data = brg_reload_value;
        usp_pkg::ADDR_BAUD_CTRL:  next_rd_data = baud_ctrl;
        usp_pkg::ADDR_POWER_CTRL: next_rd_data = power_ctrl;
        default:                  next_rd_data = 8'h00;
      endcase
    end
  end

  // Transmitter and shift-mode engine.
  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt   = tx_cnt;
    next_tx_bit   = tx_bit;
    next_tx_shift = tx_shift;
    next_m0_phase = m0_phase;
    next_m0_rx    = m0_rx;
    next_txd_out  = txd_out;
    next_rxd_out  = rxd_out;
    next_rxd_oe   = rxd_oe;
    ti_set        = 1'b0;
    ri_m0_set     = 1'b0;
    if (tx_state != usp_pkg::USP_TX_IDLE && tx_state != usp_pkg::USP_TX_SHIFT && tx_tick16) begin
      next_tx_cnt = 4'(tx_cnt + 4'h1);
    end
    unique case (tx_state)
      usp_pkg::USP_TX_IDLE: begin
        next_tx_cnt   = 4'h0;
        next_tx_bit   = 3'h0;
        next_m0_phase = 1'b0;
        next_txd_out  = 1'b1;
        if (wr_en && addr == usp_pkg::ADDR_SERIAL_BUFFER) begin
          next_tx_shift = wr_data;
          if (mode == usp_pkg::MODE_SHIFT) begin
            next_tx_state = usp_pkg::USP_TX_SHIFT;
            next_m0_rx    = 1'b0;
            next_rxd_out  = wr_data[0];
            next_rxd_oe   = 1'b1;
          end else begin
            next_tx_state = usp_pkg::USP_TX_START;
            next_txd_out  = 1'b0;
          end
        end else if (mode == usp_pkg::MODE_SHIFT && serial_control[usp_pkg::SC_REN] && !serial_control[usp_pkg::SC_RI]) begin
          next_tx_state = usp_pkg::USP_TX_SHIFT;
          next_m0_rx    = 1'b1;
          next_rxd_oe   = 1'b0;
        end
      end
      usp_pkg::USP_TX_START: begin
        if (tx_tick16 && tx_cnt == usp_pkg::OVS_LAST) begin
          next_tx_state = usp_pkg::USP_TX_DATA;
          next_txd_out  = tx_shift[0];
        end
      end
      usp_pkg::USP_TX_DATA: begin
        if (tx_tick16 && tx_cnt == usp_pkg::OVS_LAST) begin
          if (tx_bit == usp_pkg::BIT_LAST) begin
            next_tx_state = mode[1] ? usp_pkg::USP_TX_NINTH : usp_pkg::USP_TX_STOP;
            next_txd_out  = mode[1] ? serial_control[usp_pkg::SC_TB8] : 1'b1;
            ti_set        = ~mode[1];
          end else begin
            next_tx_bit   = 3'(tx_bit + 3'h1);
            next_tx_shift = {1'b0, tx_shift[7:1]};
            next_txd_out  = tx_shift[1];
          end
        end
      end
      usp_pkg::USP_TX_NINTH: begin
        if (tx_tick16 && tx_cnt == usp_pkg::OVS_LAST) begin
          next_tx_state = usp_pkg::USP_TX_STOP;
          next_txd_out  = 1'b1;
          ti_set        = 1'b1;
        end
      end
      usp_pkg::USP_TX_STOP: begin
        if (tx_tick16 && tx_cnt == usp_pkg::OVS_LAST) begin
          next_tx_state = usp_pkg::USP_TX_IDLE;
        end
      end
      usp_pkg::USP_TX_SHIFT: begin
        if (m0_half) begin
          next_m0_phase = ~m0_phase;
          next_txd_out  = m0_phase;
          if (m0_phase) begin
            next_tx_shift = {m0_rx ? rxd_sync : 1'b0, tx_shift[7:1]};
            next_rxd_out  = tx_shift[1];
            if (tx_bit == usp_pkg::BIT_LAST) begin
              next_tx_state = usp_pkg::USP_TX_IDLE;
              next_rxd_oe   = 1'b0;
              ti_set        = ~m0_rx;
              ri_m0_set     = m0_rx;
            end else begin
              next_tx_bit = 3'(tx_bit + 3'h1);
            end
          end
        end
        if (m0_rx && !serial_control[usp_pkg::SC_REN]) begin
          next_tx_state = usp_pkg::USP_TX_IDLE;
          next_txd_out  = 1'b1;
        end
      end
      default: next_tx_state = usp_pkg::USP_TX_IDLE;
    endcase
    if (ri_m0_set) begin
      next_tx_shift = {rxd_sync, tx_shift[7:1]};
    end
  end

  // Input synchroniser for the receive pin.
  always_ff @(posedge clk) begin
    if (reset) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd_in;
      rxd_sync <= rxd_meta;
    end
  end

  // All other block state registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_control       <= usp_pkg::SERIAL_CONTROL_RESET;
      fe         <= 1'b0;
      serial_buffer_rx    <= usp_pkg::OTHER_RESET;
      slave_address      <= usp_pkg::SLAVE_ADDRESS_RESET;
      slave_address_mask      <= usp_pkg::SLAVE_ADDRESS_MASK_RESET;
      brg_reload_value        <= usp_pkg::OTHER_RESET;
      baud_ctrl  <= usp_pkg::OTHER_RESET;
      power_ctrl <= usp_pkg::OTHER_RESET;
      rd_data    <= 8'h00;
      m0_cnt     <= 2'h0;
      fix_tog    <= 1'b0;
      brg_tog_a  <= 1'b0;
      brg_tog_b  <= 1'b0;
      t1_tog     <= 1'b0;
      tx_state   <= usp_pkg::USP_TX_IDLE;
      tx_cnt     <= 4'h0;
      tx_bit     <= 3'h0;
      tx_shift   <= 8'h00;
      m0_phase   <= 1'b0;
      m0_rx      <= 1'b0;
      txd_out    <= 1'b1;
      rxd_out    <= 1'b1;
      rxd_oe     <= 1'b0;
    end else begin
      serial_control       <= next_serial_control;
      fe         <= next_fe;
      serial_buffer_rx    <= next_serial_buffer_rx;
      slave_address      <= next_slave_address;
      slave_address_mask      <= next_slave_address_mask;
      brg_reload_value        <= next_brl;
      baud_ctrl  <= next_baud_ctrl;
      power_ctrl <= next_power_ctrl;
      rd_data    <= next_rd_data;
      m0_cnt     <= next_m0_cnt;
      fix_tog    <= next_fix_tog;
      brg_tog_a  <= next_brg_tog_a;
      brg_tog_b  <= next_brg_tog_b;
      t1_tog     <= next_t1_tog;
      tx_state   <= next_tx_state;
      tx_cnt     <= next_tx_cnt;
      tx_bit     <= next_tx_bit;
      tx_shift   <= next_tx_shift;
      m0_phase   <= next_m0_phase;
      m0_rx      <= next_m0_rx;
      txd_out    <= next_txd_out;
      rxd_out    <= next_rxd_out;
      rxd_oe     <= next_rxd_oe;
    end
  end
endmodule : usp_serial_port

// File: test/usp_serial_port_checker.sv
// Port assertions for the serial port.
`timescale 1ns/10ps
module usp_serial_port_checker (
  // Clock and reset.
  input wire logic       clk,
  input wire logic       reset,
  // Register port.
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  input wire logic       bit_wr,
  input wire logic [2:0] bit_index,
  input wire logic       bit_value,
  // Serial pins.
  input wire logic       rxd_oe,
  input wire logic       txd_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Buffer write while the line idles.
  sequence buf_wr_s;
    wr_en && addr == 8'h99 && txd_out && !rxd_oe;
  endsequence
  // Address write followed at once by its read.
  property addr_back_p;
    logic [7:0] v;
    (wr_en && addr == 8'hA9, v = wr_data) ##1 (rd_en && addr == 8'hA9) |=> rd_data == v;
  endproperty
  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("stray read data");
  rst_out_a: assert property ($past(reset) |-> txd_out && !rxd_oe && rd_data == 8'h00)
    else $error("bad reset outputs");
  bad_addr_a: assert property (rd_en && addr == 8'h00 |=> rd_data == 8'h00)
    else $error("unmapped read");
  tx_start_a: assert property (buf_wr_s |=> txd_out == rxd_oe)
    else $error("no start bit");
  low_hold_a: assert property ($fell(txd_out) && !rxd_oe |-> !txd_out [*8])
    else $error("short low bit");
  high_hold_a: assert property ($rose(txd_out) && !rxd_oe |-> txd_out [*8])
    else $error("short high bit");
  addr_back_a: assert property (addr_back_p)
    else $error("address readback");
  bit_wr_a: assert property (bit_wr && bit_index == 3'h4 ##1 rd_en && addr == 8'h98 |=> rd_data[4] == $past(bit_value, 2))
    else $error("bit write lost");
endmodule : usp_serial_port_checker

// File: test/usp_far_node.sv
// Far serial node that sends frames to the port.
`timescale 1ns/10ps
module usp_far_node (
  // Clock.
  input wire logic clk,
  // Serial line.
  output logic     line
);
  initial line = 1'b1;
  // Sends start, data LSB first, ninth and stop bits, 16 clocks each.
  task automatic send(input logic [7:0] d, input logic ninth, input logic stop);
    logic [10:0] f;
    f = {stop, ninth, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (16) @(posedge clk);
    end
    line <= 1'b1;
  endtask : send
endmodule : usp_far_node

// File: test/usp_serial_port_tb.sv
// Self-checking bench for the serial port.
`timescale 1ns/10ps
module usp_serial_port_tb;
  logic clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, bit_wr = 1'b0, bit_value = 1'b0;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, rd_data;
  logic [2:0] bit_index = 3'h0;
  logic rxd, rxd_out, rxd_oe, txd_out, t1 = 1'b0;
  int failures = 0, check_count = 0, cyc = 0;
  usp_serial_port dut (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .bit_wr(bit_wr), .bit_index(bit_index), .bit_value(bit_value), .timer1_overflow(t1),
    .timer2_overflow(1'b0), .tx_timer2_select(1'b0), .rx_timer2_select(1'b0), .rxd_in(rxd), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out));
  usp_far_node far (.clk(clk), .line(rxd));
  // Clock and hang guard.
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data & m, e);
  endtask : rd
  task automatic bw(input logic [2:0] i, input logic v);
    bit_index <= i;
    bit_value <= v;
    bit_wr <= 1'b1;
    @(posedge clk);
    bit_wr <= 1'b0;
    #1;
  endtask : bw
  task automatic t_regs();
    rd(8'h98, 8'hFF, 8'h00);
    rd(8'hB9, 8'hFF, 8'h00);
    rd(8'h00, 8'hFF, 8'h00);
    wr(8'hA9, 8'h5A);
    rd(8'hA9, 8'hFF, 8'h5A);
    $display("regs done");
  endtask : t_regs
  task automatic t_tx();
    logic [10:0] f;
    f = {1'b1, 1'b1, 8'hA5, 1'b0};
    wr(8'h87, 8'h80);
    wr(8'h98, 8'h88);
    wr(8'h99, 8'hA5);
    for (int n = 0; n < 4 && txd_out; n++) @(posedge clk);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      #1 chk({7'h00, txd_out}, {7'h00, f[i]});
      repeat (16) @(posedge clk);
    end
    rd(8'h98, 8'h02, 8'h02);
    $display("tx done");
  endtask : t_tx
  task automatic t_rx();
    wr(8'h98, 8'h90);
    far.send(8'h3C, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    rd(8'h98, 8'hFF, 8'h95);
    rd(8'h99, 8'hFF, 8'h3C);
    wr(8'h87, 8'hC0);
    bw(3'h0, 1'b0);
    far.send(8'h5A, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    rd(8'h98, 8'h80, 8'h80);
    bw(3'h0, 1'b0);
    far.send(8'h5A, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    rd(8'h98, 8'h80, 8'h80);
    bw(3'h7, 1'b0);
    rd(8'h98, 8'h80, 8'h00);
    bw(3'h0, 1'b0);
    bw(3'h4, 1'b0);
    rd(8'h98, 8'h11, 8'h00);
    far.send(8'h77, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    rd(8'h98, 8'h01, 8'h00);
    $display("rx done");
  endtask : t_rx
  // Mode 1: receive on timer 1 ticks, transmit on the internal generator at clock over 32.
  task automatic t_m1();
    logic [9:0] f;
    f = {1'b1, 8'h96, 1'b0};
    t1 <= 1'b1;
    wr(8'h87, 8'h80);
    wr(8'h98, 8'h50);
    far.send(8'hC3, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
    rd(8'h98, 8'hFF, 8'h55);
    rd(8'h99, 8'hFF, 8'hC3);
    wr(8'h9A, 8'hFF);
    wr(8'h9B, 8'h1A);
    wr(8'h99, 8'h96);
    repeat (16) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      #1 chk({7'h00, txd_out}, {7'h00, f[i]});
      repeat (32) @(posedge clk);
    end
    $display("mode 1 done");
  endtask : t_m1
  // Mode 0: shifted data on the receive pin, six clocks per shift clock period.
  task automatic t_m0();
    logic [7:0] d;
    int t0;
    d = 8'hB4;
    t0 = 0;
    wr(8'h98, 8'h00);
    wr(8'h99, d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_out) #1 chk({6'h00, rxd_oe, rxd_out}, {6'h00, 1'b1, d[i]});
      if (i == 0) t0 = cyc;
    end
    chk(8'(cyc - t0), 8'h2A);
    repeat (4) @(posedge clk);
    rd(8'h98, 8'h02, 8'h02);
    $display("mode 0 done");
  endtask : t_m0
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Reset, then the scenarios.
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_m1();
    t_m0();
    complete_run();
  end
endmodule : usp_serial_port_tb
bind usp_serial_port usp_serial_port_checker asrt (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .bit_wr(bit_wr), .bit_index(bit_index), .bit_value(bit_value),
  .rxd_oe(rxd_oe), .txd_out(txd_out));
